// ### rtl/fpg_gpio.sv
// four pin gpio with msi requests and an axi4-lite register slave
//
// Notes on behaviour
// [RULE_01] two-bit mode per pin, reset input
// [RULE_02] pin n mode at bits 2n+1:2n
// [RULE_03] irq mode: falling edge requests msi n
// [RULE_04] level register shows sampled pins, upper zero
// [RULE_05] level register read-only, writes ignored
// [RULE_06] output register drives pins in output modes
// [RULE_07] output register reads back stored value
// [RULE_08] open drain: low on 0, released on 1
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "fpg_params.svh"
module fpg_gpio
  import fpg_pkg::*;
#(
  parameter int PINS = `FPG_PIN_COUNT
) (
  // clock and reset
  input  wire logic             mclk_in,
  input  wire logic             reset_in,
  // axi4-lite write address
  input  wire logic [11:0]      s_awaddr_in,
  input  wire logic             s_awvalid_in,
  output logic                  s_awready_out,
  // axi4-lite write data
  input  wire logic [31:0]      s_wdata_in,
  input  wire logic [3:0]       s_wstrb_in,
  input  wire logic             s_wvalid_in,
  output logic                  s_wready_out,
  // axi4-lite write response
  output logic [1:0]            s_bresp_out,
  output logic                  s_bvalid_out,
  input  wire logic             s_bready_in,
  // axi4-lite read address
  input  wire logic [11:0]      s_araddr_in,
  input  wire logic             s_arvalid_in,
  output logic                  s_arready_out,
  // axi4-lite read data
  output logic [31:0]           s_rdata_out,
  output logic [1:0]            s_rresp_out,
  output logic                  s_rvalid_out,
  input  wire logic             s_rready_in,
  // pins
  input  wire logic [PINS-1:0]  gpio_in,
  output logic [PINS-1:0]       gpio_out,
  output logic [PINS-1:0]       gpio_oe_out,
  // msi request, one cycle pulse per event
  output logic                  msi_req_out,
  output logic [1:0]            msi_vector_out,
  // level interrupt
  output logic                  irq_out
);

  // decode, vector width and mode byte serve four pins only
  if (PINS != `FPG_PIN_COUNT) begin : g_pins_check
    $error("fpg_gpio serves exactly four pins");
  end
  if (`FPG_MODE_BITS * PINS != 8) begin : g_mode_check
    $error("mode fields must fill one byte");
  end

  // bus response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0]      mode_reg;
  logic [PINS-1:0] out_reg;
  logic [PINS-1:0] level_reg;
  logic [PINS-1:0] stat_reg;
  logic [PINS-1:0] mask_reg;
  fpg_msi_t        msi_reg;
  logic [PINS-1:0] pend_reg;
  logic            irq_reg;

  // write and read channel holding
  logic            aw_held_reg;
  logic            w_held_reg;
  fpg_wreq_t       wreq_reg;
  logic            bvalid_reg;
  logic [1:0]      bresp_reg;
  logic            rvalid_reg;
  logic [31:0]     rdata_reg;
  logic [1:0]      rresp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // pins

  logic [PINS-1:0] level_w;
  logic [PINS-1:0] fall_w;

  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_pin
      fpg_pin_cell u_cell (
        .mclk_in    (mclk_in),
        .reset_in   (reset_in),
        .mode_in    (fpg_mode_t'(mode_reg[2*gi +: `FPG_MODE_BITS])), // [RULE_02]
        .out_bit_in (out_reg[gi]),
        .pin_in     (gpio_in[gi]),
        .pin_out    (gpio_out[gi]),
        .pin_oe_out (gpio_oe_out[gi]),
        .level_out  (level_w[gi]),
        .fall_out   (fall_w[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // decode

  function automatic logic [3:0] fpg_strb_merge_sel(input logic [11:0] a);
    // one hot: mode, out, stat, mask
    fpg_strb_merge_sel = {a == `FPG_OFS_IRQ_MASK, a == `FPG_OFS_IRQ_STAT,
                          a == `FPG_OFS_OUT, a == `FPG_OFS_MODE};
  endfunction : fpg_strb_merge_sel

  function automatic logic fpg_mapped(input logic [11:0] a);
    fpg_mapped = (|fpg_strb_merge_sel(a)) || (a == `FPG_OFS_LEVEL);
  endfunction : fpg_mapped

  // lowest set bit wins, so simultaneous edges leave in pin order
  function automatic logic [1:0] fpg_lowest_idx(input logic [3:0] v);
    fpg_lowest_idx = 2'd0;
    for (int i = 3; i >= 0; i--) begin
      if (v[i]) begin
        fpg_lowest_idx = 2'(i);
      end
    end
  endfunction : fpg_lowest_idx

  wire       aw_take  = s_awvalid_in && !aw_held_reg && !bvalid_reg;
  wire       w_take   = s_wvalid_in && !w_held_reg && !bvalid_reg;
  wire       aw_have  = aw_held_reg || aw_take;
  wire       w_have   = w_held_reg || w_take;
  wire       wr_fire  = aw_have && w_have;
  wire [11:0] wr_addr = aw_held_reg ? wreq_reg.addr : s_awaddr_in;
  wire [31:0] wr_data = w_held_reg ? wreq_reg.data : s_wdata_in;
  wire [3:0]  wr_strb = w_held_reg ? wreq_reg.strb : s_wstrb_in;
  wire [3:0]  wr_sel  = wr_fire ? fpg_strb_merge_sel(wr_addr) : 4'h0;
  wire        wr_lo   = wr_strb[0];
  // level register never written: writes there just answer okay
  wire        wr_ok   = fpg_mapped(wr_addr); // [RULE_05]

  // read data is chosen while the address is offered
  wire        rd_take = s_arvalid_in && !rvalid_reg;
  wire [11:0] ra      = s_araddr_in;
  wire [31:0] rd_val  =
    (ra == `FPG_OFS_MODE)     ? {24'h00_0000, mode_reg} :
    (ra == `FPG_OFS_LEVEL)    ? {28'h000_0000, level_reg} : // [RULE_04]
    (ra == `FPG_OFS_OUT)      ? {28'h000_0000, out_reg} :   // [RULE_07]
    (ra == `FPG_OFS_IRQ_STAT) ? {28'h000_0000, stat_reg} :
    (ra == `FPG_OFS_IRQ_MASK) ? {28'h000_0000, mask_reg} :
                                32'h0000_0000;

  // strobe lane 0 carries every field, so it gates every write
  wire            wr_mode   = wr_sel[0] && wr_lo;
  wire            wr_out    = wr_sel[1] && wr_lo;
  wire            wr_stat   = wr_sel[2] && wr_lo;
  wire            wr_mask   = wr_sel[3] && wr_lo;

  // set wins over write-one-to-clear
  wire [PINS-1:0] stat_clr  = wr_stat ? wr_data[PINS-1:0] : '0;
  wire [PINS-1:0] stat_next = (stat_reg & ~stat_clr) | fall_w;

  // msi: one pulse per cycle, lowest pending pin first
  wire [PINS-1:0] pend_all  = pend_reg | fall_w;
  wire [PINS-1:0] pick      = pend_all & (~pend_all + {{(PINS-1){1'b0}}, 1'b1});
  wire [1:0]      pick_idx  = fpg_lowest_idx(pick);
  wire [PINS-1:0] pend_next = pend_all & ~pick;

  // register next values
  wire [7:0]      mode_next = wr_mode ? wr_data[7:0] : mode_reg;
  wire [PINS-1:0] out_next  = wr_out ? wr_data[PINS-1:0] : out_reg;
  wire [PINS-1:0] mask_next = wr_mask ? wr_data[PINS-1:0] : mask_reg;
  // registered so the interrupt line never glitches on a decode
  wire            irq_next  = |(stat_next & mask_next);

  // write channel: each half waits for its partner
  wire            aw_held_next = aw_have && !wr_fire;
  wire            w_held_next  = w_have && !wr_fire;
  wire            bvalid_next  = wr_fire || (bvalid_reg && !s_bready_in);
  wire [1:0]      bresp_next   = wr_ok ? RESP_OKAY : RESP_SLVERR;

  // handshake outputs straight from the holding flags
  assign s_awready_out  = !aw_held_reg && !bvalid_reg;
  assign s_wready_out   = !w_held_reg && !bvalid_reg;
  assign s_bvalid_out   = bvalid_reg;
  assign s_bresp_out    = bresp_reg;
  assign s_arready_out  = !rvalid_reg;
  assign s_rvalid_out   = rvalid_reg;
  assign s_rdata_out    = rdata_reg;
  assign s_rresp_out    = rresp_reg;
  assign msi_req_out    = msi_reg.valid;
  assign msi_vector_out = msi_reg.vector;
  assign irq_out        = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // state

  // pin drivers follow these two without delay
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      mode_reg <= `FPG_MODE_RST; // [RULE_01]
      out_reg  <= `FPG_OUT_RST; // [RULE_06]
    end else begin
      mode_reg <= mode_next; // [RULE_01] [RULE_02]
      out_reg  <= out_next; // [RULE_06]
    end
  end

  // bus writes never reach the level register
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      level_reg <= `FPG_LEVEL_RST; // [RULE_05]
    end else begin
      level_reg <= level_w; // [RULE_04] [RULE_05]
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      stat_reg <= `FPG_STAT_RST;
      mask_reg <= `FPG_MASK_RST;
      irq_reg  <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      irq_reg  <= irq_next;
    end
  end

  // pending edges survive until their pulse is sent
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      pend_reg <= '0;
      msi_reg  <= '0;
    end else begin
      pend_reg       <= pend_next;
      msi_reg.valid  <= |pend_all; // [RULE_03]
      msi_reg.vector <= pick_idx; // [RULE_03]
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg  <= w_held_next;
      bvalid_reg  <= bvalid_next;
      if (wr_fire) begin
        bresp_reg <= bresp_next;
      end
    end
  end

  // a half that arrives alone is parked until its partner comes
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      wreq_reg <= '0;
    end else begin
      if (aw_take) begin
        wreq_reg.addr <= s_awaddr_in;
      end
      if (w_take) begin
        wreq_reg.data <= s_wdata_in;
        wreq_reg.strb <= s_wstrb_in;
      end
    end
  end

  // read answer stands until the master takes it
  wire        rvalid_next = rd_take || (rvalid_reg && !s_rready_in);
  wire [1:0]  rresp_next  = fpg_mapped(ra) ? RESP_OKAY : RESP_SLVERR;

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end else begin
      rvalid_reg <= rvalid_next;
      if (rd_take) begin
        rdata_reg <= rd_val;
        rresp_reg <= rresp_next;
      end
    end
  end

endmodule : fpg_gpio
`default_nettype wire

// ### rtl/fpg_params.svh
// register offsets, field positions and reset values of the gpio block
`ifndef FPG_PARAMS_SVH
`define FPG_PARAMS_SVH

`define FPG_OFS_MODE       12'h0214
`define FPG_OFS_LEVEL      12'h0218
`define FPG_OFS_OUT        12'h021C
`define FPG_OFS_IRQ_STAT   12'h0224
`define FPG_OFS_IRQ_MASK   12'h0228
`define FPG_MODE_RST       8'h00
`define FPG_OUT_RST        4'h0
`define FPG_LEVEL_RST      4'h0
`define FPG_STAT_RST       4'h0
`define FPG_MASK_RST       4'h0
`define FPG_MODE_BITS      2
`define FPG_PIN_COUNT      4

`endif

// ### rtl/fpg_pkg.sv
// types shared by the gpio block
package fpg_pkg;

  typedef enum logic [1:0] {
    FPG_MODE_IN,
    FPG_MODE_PUSH,
    FPG_MODE_OD,
    FPG_MODE_IRQ
  } fpg_mode_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } fpg_wreq_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] vector;
  } fpg_msi_t;

endpackage : fpg_pkg

// ### rtl/fpg_pin_cell.sv
// one gpio pin: synchroniser, drivers and falling edge detect
`timescale 1ns/1ps
`default_nettype none
module fpg_pin_cell
  import fpg_pkg::*;
(
  // clock and reset
  input  wire logic       mclk_in,
  input  wire logic       reset_in,
  // control
  input  wire fpg_mode_t  mode_in,
  input  wire logic       out_bit_in,
  // pin
  input  wire logic       pin_in,
  output logic            pin_out,
  output logic            pin_oe_out,
  // status
  output logic            level_out,
  output logic            fall_out
);

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // level sensed in every mode
  assign level_out = sync_reg; // [RULE_04]
  // edge only in interrupt mode; pin stays an input there
  assign fall_out = (mode_in == FPG_MODE_IRQ) && prev_reg && !sync_reg; // [RULE_03]
  // open drain only ever drives low, pull-up makes the high
  assign pin_out = (mode_in == FPG_MODE_PUSH) ? out_bit_in : 1'b0; // [RULE_08]
  assign pin_oe_out = (mode_in == FPG_MODE_PUSH) ||
                      ((mode_in == FPG_MODE_OD) && !out_bit_in); // [RULE_06] [RULE_08]

endmodule : fpg_pin_cell
`default_nettype wire

// ### bench/fpg_gpio_monitor.sv
// port checker for the gpio block
`timescale 1ns/1ps
`default_nettype none
module fpg_gpio_monitor #(
  parameter int PINS = 4
) (
  // clock and reset
  input  wire logic            mclk_in,
  input  wire logic            reset_in,
  // bus
  input  wire logic [1:0]      s_bresp_out,
  input  wire logic            s_bvalid_out,
  input  wire logic            s_bready_in,
  input  wire logic            s_arvalid_in,
  input  wire logic            s_arready_out,
  input  wire logic [31:0]     s_rdata_out,
  input  wire logic [1:0]      s_rresp_out,
  input  wire logic            s_rvalid_out,
  input  wire logic            s_rready_in,
  // pins and msi
  input  wire logic [PINS-1:0] gpio_oe_out,
  input  wire logic            msi_req_out,
  input  wire logic [1:0]      msi_vector_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  ////////////////////////////////////////////////////////////////////////////
  rd_upper_a:
    assert property (s_rvalid_out |-> s_rdata_out[31:8] == '0)
    else $error("upper read bits set");
  rd_answer_a:
    assert property (s_arvalid_in && s_arready_out |=> s_rvalid_out)
    else $error("read not answered next cycle");
  rd_done_a:
    assert property (s_rvalid_out && s_rready_in |=> !s_rvalid_out)
    else $error("read answer repeated");
  ar_block_a:
    assert property (s_rvalid_out |-> !s_arready_out)
    else $error("read address taken while answering");
  rd_resp_a:
    assert property (s_rvalid_out |-> !s_rresp_out[0])
    else $error("bad read response code");
  wr_done_a:
    assert property (s_bvalid_out && s_bready_in |=> !s_bvalid_out)
    else $error("write response repeated");
  wr_resp_a:
    assert property (s_bvalid_out |-> s_bresp_out inside {2'b00, 2'b10})
    else $error("bad write response code");
  msi_input_a:
    assert property (msi_req_out |-> !gpio_oe_out[msi_vector_out])
    else $error("msi from a driven pin");
endmodule : fpg_gpio_monitor
`default_nettype wire

bind fpg_gpio fpg_gpio_monitor #(.PINS(PINS)) u_mon (
  .mclk_in(mclk_in), .reset_in(reset_in), .s_bresp_out(s_bresp_out),
  .s_bvalid_out(s_bvalid_out), .s_bready_in(s_bready_in),
  .s_arvalid_in(s_arvalid_in), .s_arready_out(s_arready_out),
  .s_rdata_out(s_rdata_out), .s_rresp_out(s_rresp_out),
  .s_rvalid_out(s_rvalid_out), .s_rready_in(s_rready_in),
  .gpio_oe_out(gpio_oe_out), .msi_req_out(msi_req_out),
  .msi_vector_out(msi_vector_out)
);

// ### bench/fpg_board.sv
// board model: pull-up on each pin plus an optional external driver
`timescale 1ns/1ps
`default_nettype none
module fpg_board (
  // device side
  input  wire logic [3:0] drv_in,
  input  wire logic [3:0] oe_in,
  // external driver
  input  wire logic [3:0] ext_en_in,
  input  wire logic [3:0] ext_val_in,
  // resolved pin level
  output logic [3:0]      level_out
);
  // released pin floats up unless the external driver is on, never keeps its last value
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      level_out[i] = ext_en_in[i] ? ext_val_in[i] : 1'b1;
      if (oe_in[i]) level_out[i] = drv_in[i];
    end
  end
endmodule : fpg_board
`default_nettype wire

// ### bench/tb.sv
// self-checking bench for the gpio block
`timescale 1ns/1ps
`default_nettype none
`include "fpg_params.svh"
module tb;
  logic mclk_in = 1'b0, reset_in = 1'b1;
  logic [11:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rd, q;
  logic awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0;
  logic awr, wr, bv, arr, rv, msi, irq;
  logic [1:0] bre, rre, vec;
  logic [3:0] en = '0, val = '0, ws = 4'hf, pins, gout, goe;
  int miscompares = 0, compares = 0;
  always #2.5 mclk_in = ~mclk_in;
  fpg_gpio dut (.mclk_in(mclk_in), .reset_in(reset_in), .s_awaddr_in(awa),
    .s_awvalid_in(awv), .s_awready_out(awr), .s_wdata_in(wd),
    .s_wstrb_in(ws), .s_wvalid_in(wv), .s_wready_out(wr),
    .s_bresp_out(bre), .s_bvalid_out(bv), .s_bready_in(brdy),
    .s_araddr_in(ara), .s_arvalid_in(arv), .s_arready_out(arr),
    .s_rdata_out(rd), .s_rresp_out(rre), .s_rvalid_out(rv),
    .s_rready_in(rrdy), .gpio_in(pins), .gpio_out(gout),
    .gpio_oe_out(goe), .msi_req_out(msi), .msi_vector_out(vec),
    .irq_out(irq));
  fpg_board board (.drv_in(gout), .oe_in(goe), .ext_en_in(en),
    .ext_val_in(val), .level_out(pins));
  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  // one write (w=1) or read; waits bounded, response code checked
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [1:0] er);
    logic got = 1'b0;
    logic [1:0] r = '0;
    @(posedge mclk_in);
    if (w) begin
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      brdy <= 1'b1;
    end else begin
      ara <= a;
      arv <= 1'b1;
      rrdy <= 1'b1;
    end
    for (int n = 0; n < 50 && !got; n++) begin
      @(posedge mclk_in);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
      if (arv && arr) arv <= 1'b0;
      if (brdy && bv) begin
        got = 1'b1;
        r = bre;
        brdy <= 1'b0;
      end
      if (rrdy && rv) begin
        got = 1'b1;
        r = rre;
        q = rd;
        rrdy <= 1'b0;
      end
    end
    if (!got) begin
      miscompares++;
      results();
    end
    chk(r, er);
  endtask : bus
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, '0, 2'b00);
    chk(q, e);
  endtask : rdc
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_modes;
    logic [31:0] lv;
    rdc(`FPG_OFS_MODE, 32'h0000_0000);
    rdc(`FPG_OFS_OUT, 32'h0000_0000);
    chk(goe, 4'h0);
    bus(1'b1, `FPG_OFS_OUT, 32'h0000_000a, 2'b00);
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, `FPG_OFS_MODE, {24'h0, {4{c[1:0]}}}, 2'b00);
      rdc(`FPG_OFS_MODE, {24'h0, {4{c[1:0]}}});
      chk(goe, c == 1 ? 4'hf : c == 2 ? 4'h5 : 4'h0);
      chk(gout & goe, c == 1 ? 4'ha : 4'h0);
      lv = (c[0] ^ c[1]) ? 32'h0000_000a : 32'h0000_000f;
      rdc(`FPG_OFS_LEVEL, lv);
    end
    // in, push, open drain, irq on pins 0 to 3
    bus(1'b1, `FPG_OFS_MODE, 32'h0000_00e4, 2'b00);
    bus(1'b1, `FPG_OFS_OUT, 32'h0000_0000, 2'b00);
    chk(goe, 4'h6);
    chk(gout & goe, 4'h0);
  endtask : t_modes
  task automatic t_level;
    bus(1'b1, `FPG_OFS_MODE, 32'h0000_00aa, 2'b00);
    bus(1'b1, `FPG_OFS_OUT, 32'h0000_000f, 2'b00);
    en <= 4'hf;
    repeat (4) @(posedge mclk_in);
    rdc(`FPG_OFS_LEVEL, 32'h0000_0000);
    rdc(`FPG_OFS_OUT, 32'h0000_000f);
    bus(1'b1, `FPG_OFS_MODE, 32'h0000_0000, 2'b00);
    ws <= 4'h0;
    bus(1'b1, `FPG_OFS_MODE, 32'h0000_00ff, 2'b00);
    ws <= 4'hf;
    rdc(`FPG_OFS_MODE, 32'h0000_0000);
    val <= 4'h6;
    repeat (4) @(posedge mclk_in);
    bus(1'b1, `FPG_OFS_LEVEL, 32'h0000_000f, 2'b00);
    rdc(`FPG_OFS_LEVEL, 32'h0000_0006);
    chk(goe, 4'h0);
    bus(1'b0, 12'h300, '0, 2'b10);
    chk(q, 32'h0000_0000);
  endtask : t_level
  task automatic t_irq;
    logic [3:0] hist = '0;
    int cnt = 0;
    val <= 4'hf;
    bus(1'b1, `FPG_OFS_MODE, 32'h0000_00f0, 2'b00);
    repeat (4) @(posedge mclk_in);
    val <= 4'h0;
    // only pins 2 and 3 are in irq mode
    for (int i = 0; i < 20; i++) begin
      @(posedge mclk_in);
      if (msi === 1'b1) begin
        cnt++;
        hist = {hist[1:0], vec};
      end
    end
    chk(cnt, 2);
    chk(hist, 4'hb);
    chk(irq, 1'b0);
    rdc(`FPG_OFS_IRQ_STAT, 32'h0000_000c);
    bus(1'b1, `FPG_OFS_IRQ_MASK, 32'h0000_000c, 2'b00);
    chk(irq, 1'b1);
    bus(1'b1, `FPG_OFS_IRQ_STAT, 32'h0000_000c, 2'b00);
    chk(irq, 1'b0);
  endtask : t_irq
  initial begin
    repeat (20) @(posedge mclk_in);
    reset_in <= 1'b0;
    t_modes();
    t_level();
    t_irq();
    results();
  end
endmodule : tb
`default_nettype wire
